//--- hdl/ksg_guard.sv
// key slot access guard: apb registers plus the config area access port
// assumes a secure processor that holds area_req until area_ack
`timescale 1ns/100ps
`default_nettype none
`include "ksg_params.svh"

module ksg_guard
  import ksg_pkg::*;
#(
  parameter int AW = `KSG_AW
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb register slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // config area access port
  input wire logic area_req,
  input wire logic area_write,
  input wire logic area_secure,
  input wire logic [11:0] area_addr,
  input wire logic [31:0] area_wdata,
  output logic area_ack,
  output logic [31:0] area_rdata,
  output logic area_blocked,
  // full erase
  input wire logic full_erase_request,
  output logic erase_busy,
  output logic erase_refused,
  // status mirrors
  output logic [7:0] cur_slot,
  output logic stat_hit,
  output logic stat_blocked
);

  // ========================================================================
  // state
  ksg_guard_s s_r;
  ksg_guard_s s_nxt;

  logic mem_we;
  logic [AW-1:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic otp_ok;
  logic [31:0] otp_merged;

  logic apb_acc;
  logic apb_sec;
  logic pend_sel;

  assign apb_acc = psel && penable;
  assign apb_sec = !pprot[`KSG_PPROT_NS];
  // secure select writes go through the controller so the slot header is cached
  assign pend_sel = apb_acc && pwrite && apb_sec && !s_r.pready &&
                    (paddr == `KSG_OFF_SELECT);

  // ========================================================================
  // submodules
  ksg_mem #(
    .DW(32),
    .AW(AW)
  ) u_mem (
    .clk(pclk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_r(mem_rdata)
  );

  ksg_otp_check u_otp (
    .old_word(mem_rdata),
    .new_word(s_r.q_wdata),
    .ok(otp_ok),
    .merged(otp_merged)
  );

  // ========================================================================
  // region of the latched area address
  logic q_otp;
  logic q_hdr;
  logic q_val;

  // decoded from the registered address, so the check cycle sees no adder
  always_comb begin
    q_otp = 1'b0;
    q_hdr = 1'b0;
    q_val = 1'b0;
    if (s_r.q_addr < `KSG_HDR_BASE) begin
      q_otp = 1'b1;
    end else if (s_r.q_addr < `KSG_VAL_BASE) begin
      q_hdr = 1'b1;
    end else begin
      q_val = 1'b1;
    end
  end

  // ========================================================================
  // next state
  always_comb begin
    logic is_otp;
    logic is_hdr;
    logic [9:0] hdr_off;
    logic [9:0] val_off;
    logic [6:0] acc_slot;
    logic [6:0] new_slot;
    logic match;
    logic empty;
    logic ok;
    is_otp = 1'b0;
    is_hdr = 1'b0;
    hdr_off = '0;
    val_off = '0;
    acc_slot = '0;
    new_slot = '0;
    match = 1'b0;
    empty = 1'b0;
    ok = 1'b0;
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.erefused = 1'b0;
    mem_we = 1'b0;
    mem_addr = s_r.q_addr;
    mem_wdata = s_r.q_wdata;

    if (s_r.pready) begin
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
    end

    // ----- apb registers other than secure select writes: one wait state
    if (apb_acc && !s_r.pready && !pend_sel) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = '0;
      if (!apb_sec) begin
        s_nxt.pslverr = 1'b1;
      end else if (paddr == `KSG_OFF_SELECT) begin
        s_nxt.prdata = {24'h00_0000, s_r.sel};
      end else if (paddr == `KSG_OFF_STATUS) begin
        s_nxt.prdata[`KSG_STAT_HIT] = s_r.hit;
        s_nxt.prdata[`KSG_STAT_BLK] = s_r.blk;
      end else if (paddr == `KSG_OFF_LOCK) begin
        s_nxt.prdata = s_r.lock;
        // once set the lock cannot be withdrawn short of a reset
        if (pwrite && s_r.lock == `KSG_LOCK_RESET) begin
          s_nxt.lock = pwdata;
        end
      end else if (paddr == `KSG_OFF_FWEN) begin
        s_nxt.prdata[`KSG_FWEN_BIT] = s_r.fwen;
        if (pwrite) begin
          s_nxt.fwen = pwdata[`KSG_FWEN_BIT];
        end
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end

    case (s_r.st)
      // ----- blank the whole area, once after reset or on full erase
      ST_ERASE: begin
        // the walk owns the array port; secure select writes and area requests wait
        mem_we = 1'b1;
        mem_addr = s_r.wptr;
        mem_wdata = `KSG_BLANK;
        s_nxt.wptr = s_r.wptr + 10'h001;
        if (s_r.wptr == `KSG_MEM_LAST) begin
          s_nxt.st = ST_IDLE;
          s_nxt.erasing = 1'b0;
        end
      end

      ST_IDLE: begin
        if (pend_sel) begin
          s_nxt.hit = 1'b0;
          s_nxt.blk = 1'b0;
          new_slot = 7'(pwdata[7:0] - 8'h01);
          if (pwdata > `KSG_SEL_MAX) begin
            // failing to select leaves no slot selected
            s_nxt.sel = `KSG_SEL_RESET;
            s_nxt.perm = `KSG_BLANK;
            s_nxt.blk = 1'b1;
            s_nxt.pready = 1'b1;
          end else if (pwdata[7:0] == `KSG_SEL_RESET) begin
            s_nxt.sel = `KSG_SEL_RESET;
            s_nxt.perm = `KSG_BLANK;
            s_nxt.pready = 1'b1;
          end else begin
            s_nxt.sel = pwdata[7:0];
            mem_addr = `KSG_HDR_BASE + {2'b00, new_slot, 1'b1};
            s_nxt.st = ST_FETCH;
          end
        end else if (full_erase_request) begin
          if (s_r.lock != `KSG_LOCK_RESET) begin
            s_nxt.erefused = 1'b1;
          end else begin
            s_nxt.st = ST_ERASE;
            s_nxt.wptr = '0;
            s_nxt.erasing = 1'b1;
            s_nxt.sel = `KSG_SEL_RESET;
            s_nxt.perm = `KSG_BLANK;
          end
        end else if (area_req && !s_r.ack) begin
          // ack blocks a retake of the request it answers
          s_nxt.q_we = area_write;
          s_nxt.q_sec = area_secure;
          s_nxt.q_addr = area_addr[11:2];
          s_nxt.q_wdata = area_wdata;
          mem_addr = area_addr[11:2];
          s_nxt.st = ST_CHECK;
        end
      end

      // ----- cache the selected slot's permission word
      ST_FETCH: begin
        s_nxt.perm = mem_rdata;
        s_nxt.pready = 1'b1;
        s_nxt.st = ST_IDLE;
      end

      // ----- old word is on mem_rdata; decide and answer
      ST_CHECK: begin
        is_otp = q_otp;
        is_hdr = q_hdr;
        hdr_off = s_r.q_addr - `KSG_HDR_BASE;
        val_off = s_r.q_addr - `KSG_VAL_BASE;
        acc_slot = q_val ? val_off[8:2] : hdr_off[7:1];
        match = (s_r.sel != `KSG_SEL_RESET) &&
                (acc_slot == 7'(s_r.sel - 8'h01));
        empty = (s_r.perm == `KSG_BLANK);
        if (!s_r.q_sec) begin
          ok = 1'b0;
        end else if (!s_r.q_we) begin
          if (is_otp) begin
            ok = 1'b1;
          end else if (is_hdr) begin
            ok = match;
          end else begin
            ok = match && s_r.perm[`KSG_PERM_READ] &&
                 s_r.perm[`KSG_PERM_STATE];
          end
        end else if (!s_r.fwen) begin
          ok = 1'b0;
        end else if (is_otp) begin
          ok = otp_ok;
        end else begin
          ok = match && empty && (mem_rdata == `KSG_BLANK);
        end

        // blocked writes leave the word and the cached header alone
        if (ok && s_r.q_we) begin
          mem_we = 1'b1;
          mem_wdata = is_otp ? otp_merged : s_r.q_wdata;
          if (is_hdr && s_r.q_addr[0] && match) begin
            s_nxt.perm = s_r.q_wdata;
          end
        end

        s_nxt.ack = 1'b1;
        s_nxt.ablk = !ok;
        s_nxt.ardata = '0;
        if (!s_r.q_we) begin
          s_nxt.ardata = ok ? mem_rdata : `KSG_POISON;
        end
        if (!ok) begin
          s_nxt.blk = 1'b1;
        end else if (!is_otp) begin
          s_nxt.hit = 1'b1;
        end
        s_nxt.st = ST_IDLE;
      end

      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // ========================================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.st <= ST_ERASE;
      s_r.sel <= `KSG_SEL_RESET;
      s_r.lock <= `KSG_LOCK_RESET;
      s_r.perm <= `KSG_BLANK;
      s_r.erasing <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ========================================================================
  // outputs, all from the state register
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign area_ack = s_r.ack;
  assign area_rdata = s_r.ardata;
  assign area_blocked = s_r.ablk;
  assign erase_busy = s_r.erasing;
  assign erase_refused = s_r.erefused;
  assign cur_slot = s_r.sel;
  assign stat_hit = s_r.hit;
  assign stat_blocked = s_r.blk;

endmodule : ksg_guard

`default_nettype wire

//--- hdl/ksg_params.svh
// named offsets, layouts, reset values and codes of the key slot guard
// assumes inclusion by bare name from every design file that needs them
`ifndef KSG_PARAMS_SVH
`define KSG_PARAMS_SVH

// ==========================================================================
// register offsets on apb (byte addresses)
`define KSG_OFF_SELECT 12'h000
`define KSG_OFF_STATUS 12'h004
`define KSG_OFF_LOCK 12'h008
`define KSG_OFF_FWEN 12'h00C

// ==========================================================================
// config area layout as word indices (byte address / 4)
`define KSG_AW 10
`define KSG_HDR_BASE 10'h100
`define KSG_VAL_BASE 10'h200
`define KSG_MEM_LAST 10'h3FF

// ==========================================================================
// values and field positions
`define KSG_NUM_SLOTS 128
`define KSG_SEL_RESET 8'h00
`define KSG_SEL_MAX 32'h0000_0080
`define KSG_POISON 32'hDEAD_DEAD
`define KSG_BLANK 32'hFFFF_FFFF
`define KSG_HALF_BLANK 16'hFFFF
`define KSG_LOCK_RESET 32'h0000_0000
`define KSG_PERM_READ 0
`define KSG_PERM_PUSH 1
`define KSG_PERM_STATE 2
`define KSG_STAT_HIT 0
`define KSG_STAT_BLK 1
`define KSG_FWEN_BIT 0
`define KSG_PPROT_NS 1

`endif

//--- hdl/ksg_pkg.sv
// types shared by the key slot guard modules
// assumes nothing beyond a SystemVerilog compiler
package ksg_pkg;

  typedef enum logic [1:0] {
    ST_ERASE,
    ST_IDLE,
    ST_FETCH,
    ST_CHECK
  } ksg_state_e;

  typedef struct packed {
    ksg_state_e st;
    logic [7:0] sel;
    logic hit;
    logic blk;
    logic [31:0] lock;
    logic fwen;
    logic [31:0] perm;
    logic [9:0] wptr;
    logic q_we;
    logic q_sec;
    logic [9:0] q_addr;
    logic [31:0] q_wdata;
    logic ack;
    logic [31:0] ardata;
    logic ablk;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic erasing;
    logic erefused;
  } ksg_guard_s;

endpackage : ksg_pkg

//--- hdl/ksg_mem.sv
// single-port word store standing in for the flash config area
// assumes one clock; read data registered, read before write on collision
`timescale 1ns/100ps
`default_nettype none

module ksg_mem #(
  parameter int DW = 32,
  parameter int AW = 10
) (
  // clock
  input wire logic clk,
  // access
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata_r
);

  logic [DW-1:0] mem [2**AW];

  // array has no reset: contents are non-volatile and set by the erase walk
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_r <= mem[addr];
  end

endmodule : ksg_mem

`default_nettype wire

//--- hdl/ksg_otp_check.sv
// write-once-per-halfword check for the one-time-programmable region
// assumes a full 32-bit word write; purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "ksg_params.svh"

module ksg_otp_check (
  // stored and offered words
  input wire logic [31:0] old_word,
  input wire logic [31:0] new_word,
  // verdict
  output logic ok,
  output logic [31:0] merged
);

  logic hi_keep;
  logic lo_keep;

  // a halfword offered as blank is a mask and keeps what is stored
  assign hi_keep = (new_word[31:16] == `KSG_HALF_BLANK);
  assign lo_keep = (new_word[15:0] == `KSG_HALF_BLANK);

  // a halfword may be programmed only while it still reads blank
  assign ok = (hi_keep || old_word[31:16] == `KSG_HALF_BLANK) &&
              (lo_keep || old_word[15:0] == `KSG_HALF_BLANK);
  assign merged = {hi_keep ? old_word[31:16] : new_word[31:16],
                   lo_keep ? old_word[15:0] : new_word[15:0]};

endmodule : ksg_otp_check

`default_nettype wire

//--- verif/ksg_guard_assertions.sv
// checker on the ports of the key slot guard
// assumes one clock pclk and the active-low reset presetn
`timescale 1ns/100ps
`default_nettype none

module ksg_chk (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  input wire logic pready,
  input wire logic pslverr,
  // area side and status
  input wire logic area_ack,
  input wire logic area_write,
  input wire logic area_secure,
  input wire logic [11:0] area_addr,
  input wire logic [31:0] area_rdata,
  input wire logic area_blocked,
  input wire logic [7:0] cur_slot,
  input wire logic stat_hit,
  input wire logic stat_blocked
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire logic done = psel && penable && pready;
  wire logic sel_wr = done && pwrite && paddr == 12'h000 && !pslverr;
  wire logic slot_ack = area_ack && area_addr[11:10] != 2'b00;

  // ==========================================
  // assertions
  nonsec_apb_a: assert property (done && pprot[1] |-> pslverr)
    else $error("non-secure apb access served");
  nonsec_area_a: assert property (
    area_ack && !area_secure |-> area_blocked)
    else $error("non-secure area access served");
  poison_read_a: assert property (
    area_ack && area_blocked && !area_write |-> area_rdata == 32'hDEAD_DEAD)
    else $error("blocked read without poison");
  no_select_a: assert property (
    slot_ack && cur_slot == 8'h00 |-> area_blocked)
    else $error("slot access without selection");
  bad_select_a: assert property (
    sel_wr && pwdata > 32'h0000_0080
    |-> ##[0:1] (cur_slot == 8'h00 && stat_blocked))
    else $error("out of range select kept");
  hit_flag_a: assert property (
    slot_ack && !area_blocked |-> ##[0:1] stat_hit)
    else $error("hit flag not set");
  blocked_flag_a: assert property (
    area_ack && area_blocked |-> ##[0:1] stat_blocked)
    else $error("blocked flag not set");
  select_clear_a: assert property (
    sel_wr && pwdata <= 32'h0000_0080 |-> ##[0:1] !(stat_hit || stat_blocked))
    else $error("select write kept flags");

  cover property (area_ack && area_blocked && !area_write);
  cover property (slot_ack && !area_blocked && !area_write);
  cover property (sel_wr && pwdata > 32'h0000_0080);
endmodule : ksg_chk

`default_nettype wire

//--- verif/ksg_host.sv
// processor model on the config area port of the key slot guard
// assumes acc is entered just after a rising edge of pclk
`timescale 1ns/100ps
`default_nettype none

module ksg_host (
  // clock and answer
  input wire logic pclk,
  input wire logic area_ack,
  input wire logic [31:0] area_rdata,
  input wire logic area_blocked,
  // request
  output logic area_req,
  output logic area_write,
  output logic area_secure,
  output logic [11:0] area_addr,
  output logic [31:0] area_wdata
);
  initial begin
    area_req <= 1'b0;
    area_write <= 1'b0;
    area_secure <= 1'b0;
    area_addr <= 12'h000;
    area_wdata <= 32'h0000_0000;
  end

  // one whole word per request, held up to the ack edge; dly stalls first
  task automatic acc(input logic w, s, input logic [11:0] a,
      input logic [31:0] d, input int dly,
      output logic [31:0] q, output logic b);
    repeat (dly) @(posedge pclk);
    area_req <= 1'b1;
    area_write <= w;
    area_secure <= s;
    area_addr <= a;
    area_wdata <= d;
    // only the bench watchdog ends a wait that never gets its ack
    do @(posedge pclk); while (area_ack !== 1'b1);
    q = area_rdata;
    b = area_blocked;
    area_req <= 1'b0;
    // released lines must not keep looking valid
    area_addr <= ~a;
    area_wdata <= ~d;
    @(posedge pclk);
  endtask : acc
endmodule : ksg_host

`default_nettype wire

//--- verif/tb_key_slot_access_guard.sv
// self-checking bench: registers over apb, area port through ksg_host
// assumes the design, ksg_host and ksg_chk compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "ksg_params.svh"

module tb_key_slot_access_guard;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [2:0] pprot = 3'h0;
  logic full_erase_request = 1'b0;
  logic [31:0] prdata, area_rdata, area_wdata;
  logic pready, pslverr, area_ack, area_blocked, erase_busy, erase_refused;
  logic area_req, area_write, area_secure, stat_hit, stat_blocked;
  logic [11:0] area_addr;
  logic [7:0] cur_slot;
  int miscompares = 0;
  int samples_checked = 0;

  ksg_guard dut (.*);
  ksg_host host (.*);

  always #50 pclk = ~pclk;

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  end

  // blanking walk plus all transfers need about a quarter of this span
  initial begin
    #1_000_000;
    miscompares++;
    give_verdict();
  end

  task automatic give_verdict();
    $display("checked %0d wrong %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // ==========================================
  // bus tasks
  task automatic rg(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [2:0] p,
      input logic [31:0] eq, input logic ee);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= p;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) chk("prdata", eq, prdata);
    chk("pslverr", 32'(ee), 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : rg

  task automatic ar(input logic w, s, input logic [11:0] a,
      input logic [31:0] d, eq, input logic eb);
    logic [31:0] q;
    logic b;
    host.acc(w, s, a, d, samples_checked % 3, q, b);
    chk("area_rdata", eq, q);
    chk("area_blocked", 32'(eb), 32'(b));
  endtask : ar

  task automatic sel(input logic [31:0] d, input logic [2:0] p, input logic e);
    rg(1'b1, `KSG_OFF_SELECT, d, p, 32'h0, e);
  endtask : sel

  task automatic rd(input logic [11:0] a, input logic [31:0] eq);
    rg(1'b0, a, 32'h0, 3'h0, eq, 1'b0);
  endtask : rd

  function automatic logic [31:0] key(input int k);
    return 32'hC0DE_0000 + 32'(k);
  endfunction : key

  // ==========================================
  // tests
  initial begin
    int n;
    wait (presetn === 1'b1);
    @(posedge pclk);
    rd(`KSG_OFF_SELECT, 0);
    rd(`KSG_OFF_STATUS, 0);
    rg(1, `KSG_OFF_FWEN, 1, 3'h2, 0, 1);
    rg(0, 12'h010, 0, 0, 0, 1);
    ar(1, 1, 12'h004, 32'h0000_0000, 0, 1);
    rg(1, `KSG_OFF_FWEN, 1, 0, 0, 0);
    ar(0, 1, 12'h004, 0, `KSG_BLANK, 0);
    ar(1, 1, 12'h004, 32'hFFFF_AABB, 0, 0);
    ar(1, 1, 12'h004, 32'h1234_FFFF, 0, 0);
    ar(1, 1, 12'h004, 32'h5678_FFFF, 0, 1);
    ar(1, 0, 12'h008, 32'h0000_0001, 0, 1);
    ar(0, 0, 12'h004, 0, `KSG_POISON, 1);
    ar(0, 1, 12'h004, 0, 32'h1234_AABB, 0);
    ar(0, 1, 12'h008, 0, `KSG_BLANK, 0);
    $display("test otp done");
    ar(1, 1, 12'h400, 32'h0000_1000, 0, 1);
    sel(1, 0, 0);
    ar(1, 1, 12'h400, 32'h0000_1000, 0, 0);
    for (int k = 0; k < 4; k++) begin
      ar(1, 1, 12'h800 + 12'(4 * k), key(k), 0, 0);
    end
    ar(1, 1, 12'h810, 32'h0, 0, 1);
    ar(1, 1, 12'h404, 32'h0000_0005, 0, 0);
    ar(1, 1, 12'h80C, 32'h0, 0, 1);
    rd(`KSG_OFF_STATUS, 3);
    chk("stat_hit", 1, 32'(stat_hit));
    chk("stat_blocked", 1, 32'(stat_blocked));
    sel(0, 0, 0);
    ar(0, 1, 12'h800, 0, `KSG_POISON, 1);
    sel(1, 0, 0);
    for (int k = 0; k < 4; k++) begin
      ar(0, 1, 12'h800 + 12'(4 * k), 0, key(k), 0);
    end
    rd(`KSG_OFF_STATUS, 1);
    ar(0, 1, 12'h408, 0, `KSG_POISON, 1);
    $display("test slot done");
    sel(2, 0, 0);
    ar(0, 1, 12'h810, 0, `KSG_BLANK, 0);
    ar(0, 1, 12'h408, 0, `KSG_BLANK, 0);
    sel(128, 0, 0);
    chk("cur_slot", 128, 32'(cur_slot));
    ar(0, 1, 12'h7F8, 0, `KSG_BLANK, 0);
    sel(3, 3'h2, 1);
    rd(`KSG_OFF_SELECT, 128);
    sel(129, 0, 0);
    rd(`KSG_OFF_SELECT, 0);
    rd(`KSG_OFF_STATUS, 2);
    $display("test select done");
    sel(2, 0, 0);
    ar(1, 1, 12'h408, 32'h0000_1010, 0, 0);
    for (int k = 0; k < 4; k++) begin
      ar(1, 1, 12'h810 + 12'(4 * k), key(k + 4), 0, 0);
    end
    ar(1, 1, 12'h40C, 32'h0000_0005, 0, 0);
    sel(0, 0, 0);
    sel(2, 0, 0);
    ar(0, 1, 12'h40C, 0, 32'h0000_0005, 0);
    ar(0, 1, 12'h81C, 0, key(7), 0);
    $display("test span done");
    full_erase_request <= 1'b1;
    @(posedge pclk);
    full_erase_request <= 1'b0;
    @(posedge pclk);
    chk("erase_busy", 1, 32'(erase_busy));
    rd(`KSG_OFF_SELECT, 0);
    ar(0, 1, 12'h004, 0, `KSG_BLANK, 0);
    ar(1, 1, 12'h004, 32'h1234_AABB, 0, 0);
    $display("test wipe done");
    rg(1, `KSG_OFF_LOCK, 32'hA5A5_0001, 0, 0, 0);
    rg(1, `KSG_OFF_LOCK, 0, 0, 0, 0);
    rd(`KSG_OFF_LOCK, 32'hA5A5_0001);
    full_erase_request <= 1'b1;
    n = 0;
    do @(posedge pclk); while (erase_refused !== 1'b1 && ++n < 20);
    full_erase_request <= 1'b0;
    chk("erase_refused", 1, 32'(erase_refused));
    chk("erase_busy", 0, 32'(erase_busy));
    ar(0, 1, 12'h004, 0, 32'h1234_AABB, 0);
    $display("test erase done");
    give_verdict();
  end
endmodule : tb_key_slot_access_guard

bind ksg_guard ksg_chk u_chk (.*);

`default_nettype wire
